//--- design/lgc_pkg.sv
// Shared constants, encodings and state types of the logic cell block
package lgc_pkg;

  // ****************************************************************
  // Bus and register map
  // ****************************************************************
  localparam int unsigned ADDR_W = 6;
  localparam logic [5:0] OFF_CTRL = 6'h00;
  localparam logic [5:0] OFF_POL = 6'h04;
  localparam logic [5:0] OFF_SEL0 = 6'h08;
  localparam logic [5:0] OFF_GATE0 = 6'h18;
  localparam logic [5:0] OFF_IRQ_STAT = 6'h28;
  localparam logic [5:0] OFF_IRQ_MASK = 6'h2c;
  localparam logic [5:0] REG_STRIDE = 6'h04;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // ****************************************************************
  // Field positions, write masks and reset values
  // ****************************************************************
  localparam int unsigned CTRL_EN_BIT = 7;
  localparam int unsigned CTRL_OUT_BIT = 5;
  localparam int unsigned CTRL_RISE_BIT = 4;
  localparam int unsigned CTRL_FALL_BIT = 3;
  localparam int unsigned MODE_W = 3;
  localparam int unsigned POL_OUT_BIT = 7;
  localparam logic [7:0] CTRL_RST = 8'h00;
  localparam logic [7:0] CTRL_WR_MASK = 8'h9f;
  localparam logic [7:0] POL_WR_MASK = 8'h8f;
  localparam logic [7:0] SEL_WR_MASK = 8'h1f;

  // ****************************************************************
  // Data path sizes
  // ****************************************************************
  localparam int unsigned NUM_CHAN = 4;
  localparam int unsigned SRC_W = 5;
  localparam int unsigned NUM_SRC = 32;

  // Function select encodings
  typedef enum logic [MODE_W-1:0] {
    FN_AND_OR = 3'h0,
    FN_OR_XOR = 3'h1,
    FN_AND4 = 3'h2,
    FN_SR_LATCH = 3'h3,
    FN_DFF_SR = 3'h4,
    FN_DFF2_R = 3'h5,
    FN_JK_R = 3'h6,
    FN_LATCH_SR = 3'h7
  } lgc_fn_t;

  // State of the register and bus core
  typedef struct packed {
    logic [7:0] ctrl;
    logic [7:0] pol;
    logic [NUM_CHAN-1:0][SRC_W-1:0] sel;
    logic [NUM_CHAN-1:0][7:0] gate_en;
    logic irq_stat;
    logic irq_mask;
    logic [NUM_SRC-1:0] sync1;
    logic [NUM_SRC-1:0] sync2;
    logic cell_out;
    logic out_prev;
    logic aw_have;
    logic [ADDR_W-1:0] aw_addr;
    logic w_have;
    logic [31:0] wdata;
    logic [3:0] wstrb;
    logic bvalid;
    logic [1:0] bresp;
    logic rvalid;
    logic [1:0] rresp;
    logic [31:0] rdata;
  } lgc_core_state_t;

  // State of the function stage
  typedef struct packed {
    logic q;
    logic clk_prev;
  } lgc_fn_state_t;

endpackage

//--- design/lgc_gate.sv
// One data gate: OR of enabled true or negated channels, then polarity
`timescale 1ns/1ns
`default_nettype none
module lgc_gate (
  input wire logic [3:0] data,
  input wire logic [7:0] enables,
  input wire logic invert,
  output logic gate_out
);

  // ****************************************************************
  // Gate logic
  // ****************************************************************
  // Odd bits gate the true form, even bits the negated form
  always_comb begin
    logic any;
    any = 1'b0;
    for (int i = 0; i < 4; i++) begin
      any = any | (enables[2*i+1] & data[i]) | (enables[2*i] & ~data[i]); // RL15
    end
    gate_out = any ^ invert; // RL13 RL9
  end

endmodule
`default_nettype wire

//--- design/lgc_func.sv
// Logic function stage: combinational and clocked functions of four gates
`timescale 1ns/1ns
`default_nettype none
module lgc_func (
  input wire logic clk_sys,
  input wire logic rst_n,
  input wire logic run,
  input wire logic [3:0] gate,
  input wire logic [lgc_pkg::MODE_W-1:0] mode,
  output logic result
);

  lgc_pkg::lgc_fn_state_t s_q;
  lgc_pkg::lgc_fn_state_t s_d;
  logic edge_g1;

  // ****************************************************************
  // Next state
  // ****************************************************************
  // Gate 1 acts as clock for the flip-flop modes
  always_comb begin
    s_d = s_q;
    s_d.clk_prev = gate[0];
    edge_g1 = gate[0] & ~s_q.clk_prev;
    case (lgc_pkg::lgc_fn_t'(mode)) // RL6 RL7
      lgc_pkg::FN_SR_LATCH: begin
        if (gate[0] | gate[1]) begin
          s_d.q = 1'b1;
        end else if (gate[2] | gate[3]) begin
          s_d.q = 1'b0;
        end
      end
      lgc_pkg::FN_DFF_SR: begin
        if (gate[2]) begin
          s_d.q = 1'b0;
        end else if (gate[3]) begin
          s_d.q = 1'b1;
        end else if (edge_g1) begin
          s_d.q = gate[1];
        end
      end
      lgc_pkg::FN_DFF2_R: begin
        if (gate[2]) begin
          s_d.q = 1'b0;
        end else if (edge_g1) begin
          s_d.q = gate[1] & gate[3];
        end
      end
      lgc_pkg::FN_JK_R: begin
        if (gate[2]) begin
          s_d.q = 1'b0;
        end else if (edge_g1) begin
          case ({gate[1], gate[3]})
            2'h2: s_d.q = 1'b1;
            2'h1: s_d.q = 1'b0;
            2'h3: s_d.q = ~s_q.q;
            default: s_d.q = s_q.q;
          endcase
        end
      end
      lgc_pkg::FN_LATCH_SR: begin
        if (gate[2]) begin
          s_d.q = 1'b0;
        end else if (gate[3]) begin
          s_d.q = 1'b1;
        end else if (gate[0]) begin
          s_d.q = gate[1];
        end
      end
      default: s_d.q = 1'b0;
    endcase
    // Stored state cleared while the cell is off or in reset
    if (!run || !rst_n) begin
      s_d.q = 1'b0;
    end
    if (!rst_n) begin
      s_d.clk_prev = 1'b0;
    end
  end

  // State register
  always_ff @(posedge clk_sys) begin
    s_q <= s_d;
  end

  // ****************************************************************
  // Result
  // ****************************************************************
  always_comb begin
    case (lgc_pkg::lgc_fn_t'(mode))
      lgc_pkg::FN_AND_OR: result = (gate[0] & gate[1]) | (gate[2] & gate[3]); // RL7
      lgc_pkg::FN_OR_XOR: result = (gate[0] | gate[1]) ^ (gate[2] | gate[3]); // RL7
      lgc_pkg::FN_AND4: result = &gate; // RL7
      default: result = s_q.q; // RL6
    endcase
  end

  // ****************************************************************
  // Checks
  // ****************************************************************
  chk_dff_capture: assert property (@(posedge clk_sys) disable iff (!rst_n) // RL6
    (run && mode == lgc_pkg::FN_DFF_SR && !gate[2] && !gate[3] && gate[0] && !s_q.clk_prev)
    |=> (s_q.q == $past(gate[1])))
    else $error("d flip-flop did not capture on gate 1 edge");
  chk_jk_reset: assert property (@(posedge clk_sys) disable iff (!rst_n) // RL6
    (mode == lgc_pkg::FN_JK_R && gate[2]) |=> !s_q.q)
    else $error("j-k flip-flop not cleared by reset gate");
  chk_sr_latch_set: assert property (@(posedge clk_sys) disable iff (!rst_n) // RL7
    (run && mode == lgc_pkg::FN_SR_LATCH && gate[0]) |=> result)
    else $error("s-r latch not set");

endmodule
`default_nettype wire

//--- design/lgc_cell.sv
// Configurable logic cell: register file, input select, gates, output, irq
//
// Contract
// [RL1] With the cell enable set, the cell combines selected inputs through gates and function.
// [RL2] With the cell enable clear, the cell output is held at zero.
// [RL3] The output status bit reads the cell output after output inversion; writes do nothing.
// [RL4] With rise irq enable set, a rising cell output sets the irq flag, otherwise not.
// [RL5] With fall irq enable set, a falling cell output sets the irq flag, otherwise not.
// [RL6] Function codes 111 latch, 110 J-K, 101 two-input D, 100 one-input D with set and reset.
// [RL7] Function codes 011 S-R latch, 010 four-input AND, 001 OR-XOR, 000 AND-OR.
// [RL8] The output invert bit inverts the function result before it drives the output.
// [RL9] Each gate invert bit inverts its own gate output, bit 0 for gate 1, bit 3 for gate 4.
// [RL10] Each data channel takes its source from a 5-bit selector in its own select register.
// [RL11] Undefined bits, control bit 6 and select bits 7 to 5, read as zero.
// [RL12] Reset clears the control register and keeps selections, enables and polarities.
// [RL13] Each gate combines its enabled channels; with none enabled only polarity counts.
// [RL14] Software clears the irq flag; an edge in the clearing cycle leaves it set.
// [RL15] Each gate enable register holds true and negated enables, d4 true in 7, d1 negated in 0.
`timescale 1ns/1ns
`default_nettype none
module lgc_cell #(
  parameter int unsigned NUM_SRC = lgc_pkg::NUM_SRC
) (
  input wire logic clk_sys,
  input wire logic rst_n,
  input wire logic [NUM_SRC-1:0] src_in,
  output logic cell_out,
  output logic irq,
  input wire logic [lgc_pkg::ADDR_W-1:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [lgc_pkg::ADDR_W-1:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready
);

  lgc_pkg::lgc_core_state_t s_q;
  lgc_pkg::lgc_core_state_t s_d;
  logic [3:0] chan;
  logic [3:0] gate_val;
  logic fn_result;
  logic do_wr;
  logic rise_ev;
  logic fall_ev;
  logic irq_clear;

  // ****************************************************************
  // Decode helpers
  // ****************************************************************
  // True for any mapped register offset
  function automatic logic addr_known(input logic [lgc_pkg::ADDR_W-1:0] a);
    logic hit;
    hit = (a == lgc_pkg::OFF_CTRL) || (a == lgc_pkg::OFF_POL) ||
          (a == lgc_pkg::OFF_IRQ_STAT) || (a == lgc_pkg::OFF_IRQ_MASK);
    for (int i = 0; i < lgc_pkg::NUM_CHAN; i++) begin
      hit = hit || (a == lgc_pkg::OFF_SEL0 + 6'(i) * lgc_pkg::REG_STRIDE);
      hit = hit || (a == lgc_pkg::OFF_GATE0 + 6'(i) * lgc_pkg::REG_STRIDE);
    end
    return hit;
  endfunction

  // Read value of one register, reserved bits zero
  function automatic logic [31:0] read_word(input logic [lgc_pkg::ADDR_W-1:0] a,
                                            input lgc_pkg::lgc_core_state_t st);
    logic [31:0] v;
    v = 32'h0000_0000;
    case (a)
      lgc_pkg::OFF_CTRL: begin
        v[7:0] = st.ctrl & lgc_pkg::CTRL_WR_MASK; // RL11
        v[lgc_pkg::CTRL_OUT_BIT] = st.cell_out; // RL3
      end
      lgc_pkg::OFF_POL: v[7:0] = st.pol & lgc_pkg::POL_WR_MASK; // RL11
      lgc_pkg::OFF_IRQ_STAT: v[0] = st.irq_stat;
      lgc_pkg::OFF_IRQ_MASK: v[0] = st.irq_mask;
      default: begin
        for (int i = 0; i < lgc_pkg::NUM_CHAN; i++) begin
          if (a == lgc_pkg::OFF_SEL0 + 6'(i) * lgc_pkg::REG_STRIDE) begin
            v[lgc_pkg::SRC_W-1:0] = st.sel[i]; // RL11
          end
          if (a == lgc_pkg::OFF_GATE0 + 6'(i) * lgc_pkg::REG_STRIDE) begin
            v[7:0] = st.gate_en[i];
          end
        end
      end
    endcase
    return v;
  endfunction

  // ****************************************************************
  // Data path
  // ****************************************************************
  // Channel multiplexers read only the second sync stage
  always_comb begin
    for (int i = 0; i < lgc_pkg::NUM_CHAN; i++) begin
      chan[i] = s_q.sync2[s_q.sel[i]]; // RL10
    end
  end

  // Four identical gates
  for (genvar g = 0; g < lgc_pkg::NUM_CHAN; g++) begin : g_gate
    lgc_gate u_gate (
      .data(chan),
      .enables(s_q.gate_en[g]),
      .invert(s_q.pol[g]), // RL9
      .gate_out(gate_val[g])
    );
  end

  // Function stage
  lgc_func u_func (
    .clk_sys(clk_sys),
    .rst_n(rst_n),
    .run(s_q.ctrl[lgc_pkg::CTRL_EN_BIT]),
    .gate(gate_val),
    .mode(s_q.ctrl[lgc_pkg::MODE_W-1:0]),
    .result(fn_result)
  );

  // ****************************************************************
  // Bus handshakes and events
  // ****************************************************************
  assign s_axi_awready = !s_q.aw_have;
  assign s_axi_wready = !s_q.w_have;
  assign s_axi_arready = !s_q.rvalid;
  assign do_wr = s_q.aw_have && s_q.w_have && !s_q.bvalid;
  assign rise_ev = s_q.cell_out & ~s_q.out_prev & s_q.ctrl[lgc_pkg::CTRL_RISE_BIT]; // RL4
  assign fall_ev = ~s_q.cell_out & s_q.out_prev & s_q.ctrl[lgc_pkg::CTRL_FALL_BIT]; // RL5
  assign irq_clear = do_wr && s_q.wstrb[0] && s_q.aw_addr == lgc_pkg::OFF_IRQ_STAT &&
                     s_q.wdata[0];

  // ****************************************************************
  // Next state
  // ****************************************************************
  always_comb begin
    s_d = s_q;
    // Two-stage synchroniser on every source
    s_d.sync1 = src_in;
    s_d.sync2 = s_q.sync1;
    // Output stage, zero while disabled
    s_d.out_prev = s_q.cell_out;
    if (s_q.ctrl[lgc_pkg::CTRL_EN_BIT]) begin
      s_d.cell_out = fn_result ^ s_q.pol[lgc_pkg::POL_OUT_BIT]; // RL1 RL8
    end else begin
      s_d.cell_out = 1'b0; // RL2
    end
    // Sticky flag, a new edge wins over the clear
    s_d.irq_stat = (s_q.irq_stat & ~irq_clear) | rise_ev | fall_ev; // RL4 RL5 RL14
    // Write address and data captured in either order
    if (s_axi_awvalid && s_axi_awready) begin
      s_d.aw_have = 1'b1;
      s_d.aw_addr = s_axi_awaddr;
    end
    if (s_axi_wvalid && s_axi_wready) begin
      s_d.w_have = 1'b1;
      s_d.wdata = s_axi_wdata;
      s_d.wstrb = s_axi_wstrb;
    end
    // Register write, only byte lane 0 carries data
    if (do_wr) begin
      s_d.aw_have = 1'b0;
      s_d.w_have = 1'b0;
      s_d.bvalid = 1'b1;
      s_d.bresp = addr_known(s_q.aw_addr) ? lgc_pkg::RESP_OKAY : lgc_pkg::RESP_SLVERR;
      if (s_q.wstrb[0]) begin
        case (s_q.aw_addr)
          lgc_pkg::OFF_CTRL: s_d.ctrl = s_q.wdata[7:0] & lgc_pkg::CTRL_WR_MASK; // RL3
          lgc_pkg::OFF_POL: s_d.pol = s_q.wdata[7:0] & lgc_pkg::POL_WR_MASK;
          lgc_pkg::OFF_IRQ_MASK: s_d.irq_mask = s_q.wdata[0];
          default: begin
            for (int i = 0; i < lgc_pkg::NUM_CHAN; i++) begin
              if (s_q.aw_addr == lgc_pkg::OFF_SEL0 + 6'(i) * lgc_pkg::REG_STRIDE) begin
                s_d.sel[i] = s_q.wdata[lgc_pkg::SRC_W-1:0]; // RL10
              end
              if (s_q.aw_addr == lgc_pkg::OFF_GATE0 + 6'(i) * lgc_pkg::REG_STRIDE) begin
                s_d.gate_en[i] = s_q.wdata[7:0]; // RL15
              end
            end
          end
        endcase
      end
    end
    if (s_q.bvalid && s_axi_bready) begin
      s_d.bvalid = 1'b0;
    end
    // Read answer one cycle after the address is taken
    if (s_axi_arvalid && s_axi_arready) begin
      s_d.rvalid = 1'b1;
      s_d.rdata = read_word(s_axi_araddr, s_q);
      s_d.rresp = addr_known(s_axi_araddr) ? lgc_pkg::RESP_OKAY : lgc_pkg::RESP_SLVERR;
    end else if (s_q.rvalid && s_axi_rready) begin
      s_d.rvalid = 1'b0;
    end
    // Reset clears control, irq flag and mask, output and bus state; selections, enables and polarity are kept
    if (!rst_n) begin
      s_d.ctrl = lgc_pkg::CTRL_RST; // RL12
      s_d.irq_stat = 1'b0;
      s_d.irq_mask = 1'b0;
      s_d.cell_out = 1'b0;
      s_d.out_prev = 1'b0;
      s_d.aw_have = 1'b0;
      s_d.w_have = 1'b0;
      s_d.bvalid = 1'b0;
      s_d.bresp = lgc_pkg::RESP_OKAY;
      s_d.rvalid = 1'b0;
      s_d.rresp = lgc_pkg::RESP_OKAY;
      s_d.rdata = 32'h0000_0000;
    end
  end

  // State register
  always_ff @(posedge clk_sys) begin
    s_q <= s_d;
  end

  // ****************************************************************
  // Outputs
  // ****************************************************************
  assign cell_out = s_q.cell_out;
  assign irq = s_q.irq_stat & s_q.irq_mask;
  assign s_axi_bvalid = s_q.bvalid;
  assign s_axi_bresp = s_q.bresp;
  assign s_axi_rvalid = s_q.rvalid;
  assign s_axi_rdata = s_q.rdata;
  assign s_axi_rresp = s_q.rresp;

  // ****************************************************************
  // Checks
  // ****************************************************************
  chk_disabled_out_low: assert property (@(posedge clk_sys) disable iff (!rst_n) // RL2
    !s_q.ctrl[lgc_pkg::CTRL_EN_BIT] |=> !cell_out)
    else $error("cell output not low while disabled");
  chk_and_mode_out: assert property (@(posedge clk_sys) disable iff (!rst_n) // RL1 RL8
    (s_q.ctrl[lgc_pkg::CTRL_EN_BIT] && s_q.ctrl[2:0] == lgc_pkg::FN_AND4)
    |=> cell_out == $past((&gate_val) ^ s_q.pol[lgc_pkg::POL_OUT_BIT]))
    else $error("cell output differs from inverted and of gates");
  chk_status_mirror: assert property (@(posedge clk_sys) disable iff (!rst_n) // RL3
    (s_axi_arvalid && s_axi_arready && s_axi_araddr == lgc_pkg::OFF_CTRL)
    |=> s_axi_rvalid && s_axi_rdata[lgc_pkg::CTRL_OUT_BIT] == $past(cell_out))
    else $error("status bit does not mirror cell output");
  chk_rise_flag: assert property (@(posedge clk_sys) disable iff (!rst_n) // RL4
    ($rose(cell_out) && s_q.ctrl[lgc_pkg::CTRL_RISE_BIT]) |=> s_q.irq_stat)
    else $error("rising edge did not set irq flag");
  chk_fall_flag: assert property (@(posedge clk_sys) disable iff (!rst_n) // RL5
    ($fell(cell_out) && s_q.ctrl[lgc_pkg::CTRL_FALL_BIT]) |=> s_q.irq_stat)
    else $error("falling edge did not set irq flag");
  chk_no_spurious_flag: assert property (@(posedge clk_sys) disable iff (!rst_n) // RL4 RL5
    (!s_q.irq_stat && !($rose(cell_out) && s_q.ctrl[lgc_pkg::CTRL_RISE_BIT]) &&
     !($fell(cell_out) && s_q.ctrl[lgc_pkg::CTRL_FALL_BIT])) |=> !s_q.irq_stat)
    else $error("irq flag set without enabled edge");
  chk_reserved_zero: assert property (@(posedge clk_sys) disable iff (!rst_n) // RL11
    s_axi_rvalid |-> s_axi_rdata[31:8] == 24'h00_0000 && !s_axi_rdata[6])
    else $error("reserved read bits not zero");
  chk_empty_gate_pol: assert property (@(posedge clk_sys) disable iff (!rst_n) // RL13 RL9
    s_q.gate_en[0] == 8'h00 |-> gate_val[0] == s_q.pol[0])
    else $error("empty gate output not set by polarity");
  chk_reset_ctrl: assert property (@(posedge clk_sys) // RL12
    !rst_n |=> s_q.ctrl == lgc_pkg::CTRL_RST && $stable(s_q.sel))
    else $error("reset did not clear control or changed selects");
  chk_select_route: assert property (@(posedge clk_sys) disable iff (!rst_n) // RL10
    $stable(s_q.sel[1]) |-> chan[1] == s_q.sync2[s_q.sel[1]])
    else $error("data channel 2 not routed from its selector");

endmodule
`default_nettype wire

//--- tb/lgc_cell_bench.sv
// Testbench of the logic cell: register bus, data path and interrupt
`timescale 1ns/1ns
`default_nettype none
module lgc_cell_bench;
  // ****************************************************************
  // Signals, counters and function table
  // ****************************************************************
  logic clk_sys;
  logic rst_n;
  logic [31:0] src_in;
  logic cell_out;
  logic irq;
  logic [5:0] awaddr;
  logic awvalid;
  logic awready;
  logic [31:0] wdata;
  logic wvalid;
  logic wready;
  logic [1:0] bresp;
  logic bvalid;
  logic bready;
  logic [5:0] araddr;
  logic arvalid;
  logic arready;
  logic [31:0] rdata;
  logic [1:0] rresp;
  logic rvalid;
  logic rready;
  logic [3:0] last_mode;
  int n_mismatch;
  int tests_run;
  int i;
  // Rows: function, gate 1 enables, polarity, source level, expected output
  logic [27:0] tbl [27] = '{
    28'h2_02_0e_1_1, 28'h2_02_0e_0_0, 28'h2_02_0f_0_1, 28'h2_02_8e_1_0,
    28'h2_01_0e_0_1, 28'h0_02_02_1_1, 28'h0_02_0c_0_1,
    28'h1_02_04_1_0, 28'h1_02_04_0_1, 28'h3_02_00_1_1, 28'h3_02_00_0_1,
    28'h3_02_04_0_0, 28'h4_02_02_0_0, 28'h4_02_02_1_1, 28'h4_02_00_0_1,
    28'h4_02_00_1_0, 28'h5_02_0a_0_0, 28'h5_02_0a_1_1, 28'h5_02_02_0_1,
    28'h5_02_02_1_0, 28'h6_02_02_0_0, 28'h6_02_02_1_1, 28'h6_02_0a_0_1,
    28'h6_02_0a_1_0, 28'h7_02_02_1_1, 28'h7_02_00_1_0, 28'h7_02_02_0_0
  };

  // Device under test, write strobes always full
  lgc_cell u_dut (
    .clk_sys(clk_sys), .rst_n(rst_n), .src_in(src_in), .cell_out(cell_out), .irq(irq),
    .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
    .s_axi_wdata(wdata), .s_axi_wstrb(4'hf), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
    .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready)
  );

  // ****************************************************************
  // Helper tasks
  // ****************************************************************
  // Compare and count
  task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
    tests_run++;
    if (g !== e) begin
      n_mismatch++;
      $display("ERROR %s expected %h seen %h", n, e, g);
    end
  endtask

  // Verdict and end of run
  task automatic summarize;
    if (n_mismatch == 0 && tests_run > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask

  // Let the data path settle, then stand mid-cycle
  task automatic settle;
    repeat (6) @(posedge clk_sys);
    @(negedge clk_sys);
  endtask

  // Bus write; handshakes judged mid-cycle, released after the edge
  task automatic wr(input logic [5:0] a, input logic [7:0] d,
                    input logic [1:0] er = lgc_pkg::RESP_OKAY);
    logic aw_hit;
    logic w_hit;
    logic b_hit;
    logic [1:0] rsp;
    int k;
    @(posedge clk_sys);
    awaddr <= a;
    awvalid <= 1'b1;
    wdata <= {24'h0, d};
    wvalid <= 1'b1;
    bready <= 1'b1;
    for (k = 0; k < 50; k++) begin
      @(negedge clk_sys);
      aw_hit = awvalid && awready;
      w_hit = wvalid && wready;
      b_hit = bvalid && bready;
      rsp = bresp;
      @(posedge clk_sys);
      if (aw_hit) awvalid <= 1'b0;
      if (w_hit) wvalid <= 1'b0;
      if (b_hit) begin
        bready <= 1'b0;
        chk("write response", {30'h0, er}, {30'h0, rsp});
        break;
      end
    end
    if (k == 50) begin
      n_mismatch++;
      summarize();
    end
  endtask

  // Bus read with comparison of data and response
  task automatic rd_chk(input string n, input logic [5:0] a, input logic [7:0] e,
                        input logic [1:0] er = lgc_pkg::RESP_OKAY);
    logic ar_hit;
    logic r_hit;
    logic [31:0] dat;
    logic [1:0] rsp;
    int k;
    @(posedge clk_sys);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    for (k = 0; k < 50; k++) begin
      @(negedge clk_sys);
      ar_hit = arvalid && arready;
      r_hit = rvalid && rready;
      dat = rdata;
      rsp = rresp;
      @(posedge clk_sys);
      if (ar_hit) arvalid <= 1'b0;
      if (r_hit) begin
        rready <= 1'b0;
        break;
      end
    end
    if (k == 50) begin
      n_mismatch++;
      summarize();
    end
    chk(n, {24'h0, e}, dat);
    chk(n, {30'h0, er}, {30'h0, rsp});
  endtask

  // One table row; a new function starts from a disabled cell
  task automatic run_row(input logic [27:0] r);
    if (r[27:24] != last_mode) begin
      wr(lgc_pkg::OFF_CTRL, 8'h00);
      settle();
      chk("cell_out disabled", 1'b0, cell_out);
      last_mode = r[27:24];
    end
    // Source level first, so a transparent latch never sees the new data with the old level
    src_in[19] <= r[4];
    wr(lgc_pkg::OFF_GATE0, r[23:16]);
    wr(lgc_pkg::OFF_POL, r[15:8]);
    wr(lgc_pkg::OFF_CTRL, {5'h10, r[26:24]});
    settle();
    chk("cell_out", r[0], cell_out);
    rd_chk("output status", lgc_pkg::OFF_CTRL, {2'h2, r[0], 2'h0, r[26:24]});
  endtask

  // ****************************************************************
  // Clock and main sequence
  // ****************************************************************
  // Free running system clock
  initial begin
    clk_sys = 1'b0;
    forever #2 clk_sys = ~clk_sys;
  end

  // Reset, register map, functions, interrupt, reset retention
  initial begin
    rst_n = 1'b0;
    src_in = 32'h0;
    awaddr = 6'h0;
    awvalid = 1'b0;
    wdata = 32'h0;
    wvalid = 1'b0;
    bready = 1'b0;
    araddr = 6'h0;
    arvalid = 1'b0;
    rready = 1'b0;
    last_mode = 4'hf;
    n_mismatch = 0;
    tests_run = 0;
    repeat (3) @(posedge clk_sys);
    rst_n <= 1'b1;
    rd_chk("control", lgc_pkg::OFF_CTRL, 8'h00);
    wr(lgc_pkg::OFF_CTRL, 8'h7f);
    rd_chk("control", lgc_pkg::OFF_CTRL, 8'h1f);
    for (i = 0; i < 4; i++) begin
      wr(lgc_pkg::OFF_SEL0 + 6'(4 * i), 8'hff);
      rd_chk("source select", lgc_pkg::OFF_SEL0 + 6'(4 * i), 8'h1f);
      wr(lgc_pkg::OFF_GATE0 + 6'(4 * i), 8'ha5);
      rd_chk("gate enables", lgc_pkg::OFF_GATE0 + 6'(4 * i), 8'ha5);
      wr(lgc_pkg::OFF_GATE0 + 6'(4 * i), 8'h00);
    end
    wr(lgc_pkg::OFF_SEL0, 8'h13);
    wr(lgc_pkg::OFF_POL, 8'hff);
    rd_chk("polarity", lgc_pkg::OFF_POL, 8'h8f);
    for (i = 0; i < 27; i++) begin
      run_row(tbl[i]);
    end
    // Edge interrupts with mask and write-one-to-clear
    wr(lgc_pkg::OFF_POL, 8'h0e);
    src_in[19] <= 1'b0;
    wr(lgc_pkg::OFF_CTRL, 8'h92);
    wr(lgc_pkg::OFF_IRQ_STAT, 8'h01);
    wr(lgc_pkg::OFF_IRQ_MASK, 8'h01);
    src_in[19] <= 1'b1;
    settle();
    chk("irq", 1'b1, irq);
    rd_chk("irq flag", lgc_pkg::OFF_IRQ_STAT, 8'h01);
    wr(lgc_pkg::OFF_IRQ_STAT, 8'h01);
    rd_chk("irq flag", lgc_pkg::OFF_IRQ_STAT, 8'h00);
    src_in[19] <= 1'b0;
    settle();
    rd_chk("irq flag", lgc_pkg::OFF_IRQ_STAT, 8'h00);
    wr(lgc_pkg::OFF_CTRL, 8'h8a);
    src_in[19] <= 1'b1;
    settle();
    rd_chk("irq flag", lgc_pkg::OFF_IRQ_STAT, 8'h00);
    src_in[19] <= 1'b0;
    settle();
    rd_chk("irq flag", lgc_pkg::OFF_IRQ_STAT, 8'h01);
    wr(lgc_pkg::OFF_IRQ_MASK, 8'h00);
    settle();
    chk("irq masked", 1'b0, irq);
    // Unmapped place on the bus
    rd_chk("unmapped", 6'h30, 8'h00, lgc_pkg::RESP_SLVERR);
    wr(6'h30, 8'hff, lgc_pkg::RESP_SLVERR);
    // Second reset keeps selections, enables and polarity
    rst_n <= 1'b0;
    repeat (3) @(posedge clk_sys);
    rst_n <= 1'b1;
    rd_chk("control", lgc_pkg::OFF_CTRL, 8'h00);
    rd_chk("source select", lgc_pkg::OFF_SEL0, 8'h13);
    rd_chk("polarity", lgc_pkg::OFF_POL, 8'h0e);
    rd_chk("gate enables", lgc_pkg::OFF_GATE0, 8'h02);
    summarize();
  end
endmodule
`default_nettype wire
